// File: logic/ssrb_pkg.sv
`default_nettype none
package ssrb_pkg;

  // ******************************
  // register indices (holding register numbers)
  // ******************************
  localparam logic [15:0] SSRB_IDX_STATUS = 16'h0007;
  localparam logic [15:0] SSRB_IDX_VISUAL = 16'h0009;
  localparam logic [15:0] SSRB_IDX_SPEED = 16'h000a;
  localparam logic [15:0] SSRB_IDX_DIR = 16'h000b;
  localparam logic [15:0] SSRB_IDX_MCUR = 16'h000c;
  localparam logic [15:0] SSRB_IDX_BATT = 16'h000d;
  localparam logic [15:0] SSRB_IDX_ICUR = 16'h000e;

  // ******************************
  // status word bit positions
  // ******************************
  localparam int SSRB_BIT_GPS = 0;
  localparam int SSRB_BIT_CHG = 1;
  localparam int SSRB_BIT_MOT = 2;
  localparam int SSRB_BIT_ANALOG = 3;

  // ******************************
  // health codes
  // ******************************
  localparam logic [15:0] SSRB_VIS_OK = 16'h0000;
  localparam logic [15:0] SSRB_VIS_JAM = 16'h0001;
  localparam logic [15:0] SSRB_VIS_V36 = 16'h0002;
  localparam logic [15:0] SSRB_VIS_MOT = 16'h0003;
  localparam logic [15:0] SSRB_VIS_CHG = 16'h0004;
  localparam logic [15:0] SSRB_VIS_BLIM = 16'h0005;
  localparam logic [15:0] SSRB_VIS_HICUR = 16'h0010;
  localparam logic [15:0] SSRB_VIS_LOWB = 16'h0020;
  localparam logic [15:0] SSRB_VIS_TEMP = 16'h0030;
  localparam logic [15:0] SSRB_VIS_V5 = 16'h0040;
  localparam logic [15:0] SSRB_VIS_GPS = 16'h0050;
  localparam logic [15:0] SSRB_VIS_ACQ = 16'h0100;

  // ******************************
  // direction, function code, reset values
  // ******************************
  localparam logic [15:0] SSRB_DIR_FWD = 16'h0000;
  localparam logic [15:0] SSRB_DIR_REV = 16'h0001;
  localparam logic [7:0] SSRB_FC_READ = 8'h03;
  localparam logic [15:0] SSRB_RST_WORD = 16'h0000;
  localparam logic [7:0] SSRB_MAX_REGS = 8'h7d;

  typedef enum logic [1:0] {
    SSRB_IDLE = 2'b00,
    SSRB_HEAD = 2'b01,
    SSRB_DATA = 2'b11,
    SSRB_REJ = 2'b10
  } ssrb_state_e;

endpackage
`default_nettype wire

// File: logic/ssrb_health.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_health
  import ssrb_pkg::*;
(
  // condition inputs
  input wire logic batt_limit,
  input wire logic jam_recovery,
  input wire logic v36_out_of_range,
  input wire logic aux_on,
  input wire logic mot_link_err,
  input wire logic chg_link_err,
  input wire logic hi_motor_current,
  input wire logic low_batt,
  input wire logic temp_out_of_range,
  input wire logic v5_out_of_range,
  input wire logic gps_link_err,
  input wire logic gps_acquiring,
  // code
  output logic [15:0] code
);
  always_comb begin
    // highest priority wins
    if (batt_limit) code = SSRB_VIS_BLIM;
    else if (jam_recovery) code = SSRB_VIS_JAM;
    else if (v36_out_of_range && aux_on) code = SSRB_VIS_V36;
    else if (mot_link_err && aux_on) code = SSRB_VIS_MOT;
    else if (chg_link_err) code = SSRB_VIS_CHG;
    else if (hi_motor_current) code = SSRB_VIS_HICUR;
    else if (low_batt) code = SSRB_VIS_LOWB;
    else if (temp_out_of_range) code = SSRB_VIS_TEMP;
    else if (v5_out_of_range) code = SSRB_VIS_V5;
    else if (gps_link_err) code = SSRB_VIS_GPS;
    else if (gps_acquiring) code = SSRB_VIS_ACQ;
    else code = SSRB_VIS_OK;
  end
endmodule
`default_nettype wire

// File: logic/ssrb_hold.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_hold
  import ssrb_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // sample
  input wire logic upd,
  input wire logic [15:0] din,
  // held value
  output logic [15:0] q
);
  typedef struct packed {
    logic [15:0] val;
  } ssrb_hold_s;
  ssrb_hold_s r, next_r;
  always_comb begin
    next_r = r;
    // keeps last value when no fresh sample
    if (upd) next_r.val = din;
    if (!RESETN) next_r.val = SSRB_RST_WORD;
  end
  always_ff @(posedge CLOCK) begin
    r <= next_r;
  end
  assign q = r.val;
endmodule
`default_nettype wire

// File: logic/ssrb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_bank
  import ssrb_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // subsystem error flags
  input wire logic GPS_LINK_ERR,
  input wire logic CHG_LINK_ERR,
  input wire logic MOT_LINK_ERR,
  input wire logic ANALOG_OUT_OF_RANGE,
  // indicator conditions
  input wire logic BATT_LIMIT,
  input wire logic JAM_RECOVERY,
  input wire logic V36_OUT_OF_RANGE,
  input wire logic AUX_ON,
  input wire logic HI_MOTOR_CURRENT,
  input wire logic LOW_BATT,
  input wire logic TEMP_OUT_OF_RANGE,
  input wire logic V5_OUT_OF_RANGE,
  input wire logic GPS_ACQUIRING,
  // measurements from motor module
  input wire logic MOT_VALID,
  input wire logic [15:0] MOT_SPEED,
  input wire logic MOT_REVERSE,
  input wire logic [15:0] MOT_CURRENT,
  // measurements from charge module
  input wire logic CHG_VALID,
  input wire logic [15:0] BATT_VOLTAGE,
  input wire logic [15:0] IN_CURRENT,
  // request port (decoded pdu)
  input wire logic REQ_VALID,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_COUNT,
  // reply byte stream
  input wire logic TX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic TX_EXCEPT,
  output logic BUSY,
  // live status word
  output logic [15:0] SYSTEM_STATUS
);

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    ssrb_state_e st;
    logic [15:0] status;
    logic [15:0] visual;
    logic [15:0] addr;
    logic [7:0] left;
    logic hi;
    logic [7:0] func;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_except;
    logic busy;
  } ssrb_bank_s;

  ssrb_bank_s r;
  ssrb_bank_s next_r;
  logic [15:0] vis_code;
  logic [15:0] speed_q;
  logic [15:0] mcur_q;
  logic [15:0] batt_q;
  logic [15:0] icur_q;
  logic [15:0] dir_q;

  // ******************************
  // exception codes
  // ******************************
  localparam logic [7:0] SSRB_EXC_FUNC = 8'h01;
  localparam logic [7:0] SSRB_EXC_ADDR = 8'h02;
  localparam logic [7:0] SSRB_EXC_COUNT = 8'h03;

  // ******************************
  // map lookup
  // ******************************
  function automatic logic [15:0] rd_word(
      input logic [15:0] idx,
      input ssrb_bank_s s,
      input logic [15:0] sp,
      input logic [15:0] dr,
      input logic [15:0] mc,
      input logic [15:0] bv,
      input logic [15:0] ic
  );
    case (idx)
      SSRB_IDX_STATUS: rd_word = s.status;
      SSRB_IDX_VISUAL: rd_word = s.visual;
      SSRB_IDX_SPEED: rd_word = sp;
      SSRB_IDX_DIR: rd_word = dr;
      SSRB_IDX_MCUR: rd_word = mc;
      SSRB_IDX_BATT: rd_word = bv;
      SSRB_IDX_ICUR: rd_word = ic;
      default: rd_word = 16'h0000;
    endcase
  endfunction

  function automatic logic in_map(input logic [15:0] idx);
    in_map = (idx == SSRB_IDX_STATUS) || ((idx >= SSRB_IDX_VISUAL) && (idx <= SSRB_IDX_ICUR));
  endfunction

  // status word stands alone, index 8 is a hole
  function automatic logic span_ok(input logic [15:0] idx, input logic [15:0] n);
    if (idx == SSRB_IDX_STATUS) begin
      span_ok = (n == 16'h0001);
    end else begin
      span_ok = in_map(idx) && in_map(idx + n - 16'h0001);
    end
  endfunction

  // ******************************
  // status word
  // ******************************
  function automatic logic [15:0] status_word(
      input logic gps,
      input logic chg,
      input logic mot,
      input logic ana
  );
    status_word = SSRB_RST_WORD;
    status_word[SSRB_BIT_GPS] = gps;
    status_word[SSRB_BIT_CHG] = chg;
    status_word[SSRB_BIT_MOT] = mot;
    status_word[SSRB_BIT_ANALOG] = ana;
  endfunction

  // ******************************
  // held measurements
  // ******************************
  ssrb_hold u_speed (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .upd(MOT_VALID),
    .din(MOT_SPEED),
    .q(speed_q)
  );
  ssrb_hold u_dir (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .upd(MOT_VALID),
    .din(MOT_REVERSE ? SSRB_DIR_REV : SSRB_DIR_FWD),
    .q(dir_q)
  );
  ssrb_hold u_mcur (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .upd(MOT_VALID),
    .din(MOT_CURRENT),
    .q(mcur_q)
  );
  ssrb_hold u_batt (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .upd(CHG_VALID),
    .din(BATT_VOLTAGE),
    .q(batt_q)
  );
  ssrb_hold u_icur (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .upd(CHG_VALID),
    .din(IN_CURRENT),
    .q(icur_q)
  );

  ssrb_health u_health (
    .batt_limit(BATT_LIMIT),
    .jam_recovery(JAM_RECOVERY),
    .v36_out_of_range(V36_OUT_OF_RANGE),
    .aux_on(AUX_ON),
    .mot_link_err(MOT_LINK_ERR),
    .chg_link_err(CHG_LINK_ERR),
    .hi_motor_current(HI_MOTOR_CURRENT),
    .low_batt(LOW_BATT),
    .temp_out_of_range(TEMP_OUT_OF_RANGE),
    .v5_out_of_range(V5_OUT_OF_RANGE),
    .gps_link_err(GPS_LINK_ERR),
    .gps_acquiring(GPS_ACQUIRING),
    .code(vis_code)
  );

  // ******************************
  // next state
  // ******************************
  always_comb begin
    logic [15:0] w;
    logic tx_take;
    w = 16'h0000;
    tx_take = r.tx_valid && TX_READY;
    next_r = r;
    next_r.status = status_word(GPS_LINK_ERR, CHG_LINK_ERR, MOT_LINK_ERR,
        ANALOG_OUT_OF_RANGE);
    next_r.visual = vis_code;
    if (tx_take) begin
      next_r.tx_valid = 1'b0;
      next_r.tx_last = 1'b0;
    end
    case (r.st)
      SSRB_IDLE: begin
        // a byte still waiting for the sink keeps the bank busy
        if (REQ_VALID && !r.tx_valid) begin
          next_r.func = REQ_FUNC;
          next_r.addr = REQ_ADDR;
          next_r.left = REQ_COUNT[7:0];
          next_r.hi = 1'b1;
          // writes and other functions refused, contents untouched
          if (REQ_FUNC != SSRB_FC_READ || REQ_COUNT == 16'h0000 ||
              REQ_COUNT > {8'h00, SSRB_MAX_REGS}) begin
            next_r.st = SSRB_REJ;
          end else if (!span_ok(REQ_ADDR, REQ_COUNT)) begin
            // bad address answers on the next edge, no turn through reject
            next_r.tx_valid = 1'b1;
            next_r.tx_last = 1'b1;
            next_r.tx_except = 1'b1;
            next_r.tx_data = SSRB_EXC_ADDR;
          end else begin
            next_r.st = SSRB_HEAD;
          end
        end
      end
      SSRB_HEAD: begin
        if (!r.tx_valid || tx_take) begin
          next_r.tx_valid = 1'b1;
          next_r.tx_data = {r.left[6:0], 1'b0};
          next_r.tx_except = 1'b0;
          next_r.st = SSRB_DATA;
        end
      end
      SSRB_DATA: begin
        if (!r.tx_valid || tx_take) begin
          w = rd_word(r.addr, r, speed_q, dir_q, mcur_q, batt_q, icur_q);
          next_r.tx_valid = 1'b1;
          next_r.tx_data = r.hi ? w[15:8] : w[7:0];
          next_r.hi = !r.hi;
          if (!r.hi) begin
            next_r.addr = r.addr + 16'h0001;
            next_r.left = r.left - 8'h01;
            if (r.left == 8'h01) begin
              next_r.tx_last = 1'b1;
              next_r.st = SSRB_IDLE;
            end
          end
        end
      end
      SSRB_REJ: begin
        if (!r.tx_valid || tx_take) begin
          // exception code 1 bad function, 2 bad address, 3 bad count
          next_r.tx_valid = 1'b1;
          next_r.tx_last = 1'b1;
          next_r.tx_except = 1'b1;
          next_r.tx_data = (r.func != SSRB_FC_READ) ? SSRB_EXC_FUNC : SSRB_EXC_COUNT;
          next_r.st = SSRB_IDLE;
        end
      end
      default: next_r.st = SSRB_IDLE;
    endcase
    if (!RESETN) begin
      next_r = '0;
      next_r.st = SSRB_IDLE;
    end
    // busy kept in a flop so the port needs no gates
    next_r.busy = (next_r.st != SSRB_IDLE) || next_r.tx_valid;
  end

  always_ff @(posedge CLOCK) begin
    r <= next_r;
  end

  // ******************************
  // outputs
  // ******************************
  assign TX_VALID = r.tx_valid;
  assign TX_DATA = r.tx_data;
  assign TX_LAST = r.tx_last;
  assign TX_EXCEPT = r.tx_except;
  assign BUSY = r.busy;
  assign SYSTEM_STATUS = r.status;

endmodule
`default_nettype wire

// File: tb/ssrb_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_bank_chk
  import ssrb_pkg::*;
(
  // watched ports
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic GPS_LINK_ERR,
  input wire logic CHG_LINK_ERR,
  input wire logic MOT_LINK_ERR,
  input wire logic ANALOG_OUT_OF_RANGE,
  input wire logic REQ_VALID,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_COUNT,
  input wire logic TX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_EXCEPT,
  input wire logic BUSY,
  input wire logic [15:0] SYSTEM_STATUS
);
  wire logic [3:0] errs;
  wire logic take;
  wire logic good;
  assign errs = {ANALOG_OUT_OF_RANGE, MOT_LINK_ERR, CHG_LINK_ERR, GPS_LINK_ERR};
  assign take = REQ_VALID && !BUSY;
  assign good = take && REQ_FUNC == SSRB_FC_READ && REQ_COUNT != 16'h0000
    && ((REQ_ADDR == 16'h0007 && REQ_COUNT == 16'h0001) || (REQ_ADDR >= 16'h0009
    && REQ_ADDR <= 16'h000e && REQ_COUNT <= 16'h0006 && REQ_ADDR + REQ_COUNT <= 16'h000f));
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  status_bits_a: assert property (
    $past(RESETN) |-> SYSTEM_STATUS == {12'h000, $past(errs)}) else $error("status bits");
  status_zero_a: assert property (
    $past(RESETN) |-> (SYSTEM_STATUS != 16'h0000) == $past(|errs)) else $error("status zero");
  reply_time_a: assert property (
    take |-> ##[1:2] TX_VALID) else $error("no reply");
  func_refuse_a: assert property (
    take && REQ_FUNC != SSRB_FC_READ |-> ##2 TX_VALID && TX_EXCEPT && TX_LAST)
    else $error("func");
  addr_refuse_a: assert property (
    take && REQ_FUNC == SSRB_FC_READ && REQ_COUNT != 16'h0000 && REQ_COUNT <= 16'h007d
    && !good |=> TX_VALID && TX_EXCEPT && TX_LAST && TX_DATA == 8'h02) else $error("address");
  byte_count_a: assert property (
    good |-> ##2 TX_VALID && !TX_EXCEPT && TX_DATA == {$past(REQ_COUNT[6:0], 2), 1'b0})
    else $error("byte count");
  byte_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("byte dropped");
  last_end_a: assert property (
    TX_VALID && TX_READY && TX_LAST |=> !TX_VALID) else $error("extra byte");
  except_last_a: assert property (
    TX_VALID && TX_EXCEPT |-> TX_LAST && TX_DATA != 8'h00) else $error("exception");
  cover property (take && REQ_FUNC != SSRB_FC_READ);
  cover property (TX_VALID && !TX_READY);
  cover property (good && REQ_COUNT == 16'h0006);
endmodule
bind ssrb_bank ssrb_bank_chk i_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .GPS_LINK_ERR(GPS_LINK_ERR), .CHG_LINK_ERR(CHG_LINK_ERR), .MOT_LINK_ERR(MOT_LINK_ERR),
  .ANALOG_OUT_OF_RANGE(ANALOG_OUT_OF_RANGE), .REQ_VALID(REQ_VALID), .REQ_FUNC(REQ_FUNC),
  .REQ_ADDR(REQ_ADDR), .REQ_COUNT(REQ_COUNT), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_EXCEPT(TX_EXCEPT), .BUSY(BUSY),
  .SYSTEM_STATUS(SYSTEM_STATUS));
`default_nettype wire

// File: tb/ssrb_master.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_master
  import ssrb_pkg::*;
(
  // clock and pacing
  input wire logic CLOCK,
  input wire logic slow,
  // reply stream
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_EXCEPT,
  input wire logic BUSY,
  // request and flow control
  output logic REQ_VALID,
  output logic [7:0] REQ_FUNC,
  output logic [15:0] REQ_ADDR,
  output logic [15:0] REQ_COUNT,
  output logic TX_READY
);
  logic [7:0] rx[$];
  logic exc;
  initial begin
    REQ_VALID = 1'b0;
    REQ_FUNC = 8'h00;
    REQ_ADDR = 16'h0000;
    REQ_COUNT = 16'h0000;
  end
  // slow mode drops ready every other cycle
  always @(negedge CLOCK) TX_READY <= slow ? ~TX_READY : 1'b1;
  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n);
    int t;
    logic done;
    rx = {};
    exc = 1'b0;
    t = 0;
    done = 1'b0;
    @(negedge CLOCK);
    while (BUSY && t < 100) begin
      @(negedge CLOCK);
      t++;
    end
    REQ_VALID = 1'b1;
    REQ_FUNC = f;
    REQ_ADDR = a;
    REQ_COUNT = n;
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    REQ_FUNC = ~f;
    REQ_ADDR = ~a;
    REQ_COUNT = ~n;
    t = 0;
    // look halfway into each low phase, where the coming take is already decided
    do begin
      #5;
      if (TX_VALID && TX_READY) begin
        rx.push_back(TX_DATA);
        exc = TX_EXCEPT;
        done = TX_LAST;
      end
      @(negedge CLOCK);
      t++;
    end while (!done && t < 300);
  endtask
endmodule
`default_nettype wire

// File: tb/ssrb_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module ssrb_bank_test
  import ssrb_pkg::*;
;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic slow = 1'b0;
  logic ana = 1'b0;
  logic [11:0] cnd = 12'h000;
  logic mv = 1'b0;
  logic cv = 1'b0;
  logic rev = 1'b0;
  logic [15:0] sp = 16'h0000, mc = 16'h0000, bv = 16'h0000, ic = 16'h0000;
  logic rq, rdy, tv, tl, te, bsy;
  logic [7:0] fn, td;
  logic [15:0] ad, nr, st;
  logic [39:0] rf[11] = '{40'h06_0007_0001, 40'h10_0009_0001, 40'h03_0007_0000,
    40'h03_0009_007e, 40'h03_0008_0001, 40'h03_000e_0002, 40'h03_0007_0003,
    40'h03_0000_0001, 40'h03_0009_007d, 40'h03_0009_0006, 40'h03_0007_0001};
  int m[16];
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 8430;
  int r;
  always #10 CLOCK = ~CLOCK;
  ssrb_bank i_ssrb_bank (.CLOCK(CLOCK), .RESETN(RESETN), .GPS_LINK_ERR(cnd[9]),
    .CHG_LINK_ERR(cnd[4]), .MOT_LINK_ERR(cnd[3]), .ANALOG_OUT_OF_RANGE(ana),
    .BATT_LIMIT(cnd[0]), .JAM_RECOVERY(cnd[1]), .V36_OUT_OF_RANGE(cnd[2]), .AUX_ON(cnd[11]),
    .HI_MOTOR_CURRENT(cnd[5]), .LOW_BATT(cnd[6]), .TEMP_OUT_OF_RANGE(cnd[7]),
    .V5_OUT_OF_RANGE(cnd[8]), .GPS_ACQUIRING(cnd[10]), .MOT_VALID(mv), .MOT_SPEED(sp),
    .MOT_REVERSE(rev), .MOT_CURRENT(mc), .CHG_VALID(cv), .BATT_VOLTAGE(bv), .IN_CURRENT(ic),
    .REQ_VALID(rq), .REQ_FUNC(fn), .REQ_ADDR(ad), .REQ_COUNT(nr), .TX_READY(rdy),
    .TX_VALID(tv), .TX_DATA(td), .TX_LAST(tl), .TX_EXCEPT(te), .BUSY(bsy), .SYSTEM_STATUS(st));
  ssrb_master i_m (.CLOCK(CLOCK), .slow(slow), .TX_VALID(tv), .TX_DATA(td), .TX_LAST(tl),
    .TX_EXCEPT(te), .BUSY(bsy), .REQ_VALID(rq), .REQ_FUNC(fn), .REQ_ADDR(ad),
    .REQ_COUNT(nr), .TX_READY(rdy));
  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(input string s);
    bad_count++;
    $display("Error %0t: %s", $time, s);
  endtask
  // health code, highest priority first
  function automatic int vis(input logic [11:0] k);
    if (k[0]) return 5;
    if (k[1]) return 1;
    if (k[2] && k[11]) return 2;
    if (k[3] && k[11]) return 3;
    if (k[4]) return 4;
    if (k[5]) return 16;
    if (k[6]) return 32;
    if (k[7]) return 48;
    if (k[8]) return 64;
    if (k[9]) return 80;
    return k[10] ? 256 : 0;
  endfunction
  function automatic int rv(input int a);
    if (a == 7) return {ana, cnd[3], cnd[4], cnd[9]};
    return a == 9 ? vis(cnd) : m[a];
  endfunction
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n);
    int q[$];
    int e;
    e = 0;
    if (f != 8'h03) e = 1;
    else if (n == 0 || n > 125) e = 3;
    else if (!(a == 7 && n == 1) && !(a >= 9 && a <= 14 && a + n <= 15)) e = 2;
    q = {e ? e : 2 * n};
    for (int i = 0; i < n && e == 0; i++) begin
      q.push_back(rv(a + i) >> 8);
      q.push_back(rv(a + i) & 255);
    end
    i_m.rd(f, a, n);
    total_checks++;
    if (i_m.rx.size() != q.size() || i_m.exc !== (e != 0)) fail("reply shape");
    foreach (q[i]) if (i_m.rx[i] !== q[i][7:0]) fail("reply byte");
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge CLOCK);
    RESETN = 1'b1;
    for (int i = 0; i < 16; i++) begin
      slow = i[0];
      {ana, cnd[3], cnd[4], cnd[9]} = i[3:0];
      xfer(8'h03, 16'h0007, 16'h0001);
      total_checks++;
      if (st !== 16'(i)) fail("status port");
    end
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      cnd = i < 12 ? 12'h800 | (12'h001 << i) : r[11:0] & 12'hbff;
      ana = r[12];
      slow = r[13];
      xfer(8'h03, 16'h0009, 16'h0001);
    end
    for (int i = 0; i < 3; i++) begin
      cnd = 12'h800;
      {sp, mc} = $random(seed);
      {bv, ic} = $random(seed);
      rev = i[0];
      mv = 1'b1;
      cv = 1'b1;
      @(negedge CLOCK);
      mv = 1'b0;
      cv = 1'b0;
      m[10] = sp;
      m[11] = rev;
      m[12] = mc;
      m[13] = bv;
      m[14] = ic;
      xfer(8'h03, 16'h0009, 16'h0006);
      cnd = 12'h818;
      {sp, mc, bv, ic} = ~{sp, mc, bv, ic};
      xfer(8'h03, 16'h0009, 16'h0006);
    end
    foreach (rf[i]) xfer(rf[i][39:32], rf[i][31:16], rf[i][15:0]);
    xfer(8'h03, 16'h0009, 16'h0006);
    print_verdict();
  end
endmodule
`default_nettype wire
